// [rtl/uartsb_pkg.sv]
// shared constants for the serial sync break control block
// What this block does
// - baud clock is counter output halved
// - same-value control rewrite accepted while active
// - receive trigger self-clears when communication completes
// - rewrite of 1 into cleared trigger restarts
// - break receive error returns to break wait
// - break receive error keeps status flag at 1
// - receive trigger reads 0, clears on success
package uartsb_pkg;
	// control register field positions
	localparam int UARTSB_CTL_RX_TRIG_POS = 6;
	localparam int UARTSB_CTL_TX_TRIG_POS = 5;
	localparam logic [7:0] UARTSB_CTL_RESET = 8'h01;
	// mask of stored option bits (triggers are never stored as read data)
	localparam logic [7:0] UARTSB_CTL_KEEP_MASK = 8'h1F;
	// break field lengths in bit periods
	localparam logic [4:0] UARTSB_BRK_TX_BITS = 5'h0D;
	localparam logic [4:0] UARTSB_BRK_RX_MIN_BITS = 5'h0B;
	localparam logic [4:0] UARTSB_BRK_CNT_MAX = 5'h1F;
	// reset value of the baud divisor register path
	localparam logic [7:0] UARTSB_DIV_RESET = 8'h00;
	// receive sequencer states
	typedef enum logic [1:0] {
		UARTSB_RX_IDLE = 2'b00,
		UARTSB_RX_WAIT = 2'b01,
		UARTSB_RX_LOW = 2'b10
	} uartsb_rx_state_t;
endpackage

// [rtl/uartsb_baud_gen.sv]
// 8-bit baud counter with halved output giving the bit-rate tick
`timescale 1ns/1ps
`default_nettype none
module uartsb_baud_gen
	import uartsb_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input wire logic clk_sys,
	input wire logic rst_sync_b,
	input wire logic run,
	input wire logic [DIV_W-1:0] divisor,
	output logic bit_tick
);
	// counter state and halving toggle
	logic [DIV_W-1:0] count;
	logic half;

	////////////////////////////////////////////////////////////////////////
	// counter wraps at divisor; its wrap is the counter output clock
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			count <= '0;
			half <= 1'b0;
			bit_tick <= 1'b0;
		end else if (!run) begin
			// stopped: hold phase at zero so a new start is aligned
			count <= '0;
			half <= 1'b0;
			bit_tick <= 1'b0;
		end else if (count >= divisor) begin
			count <= '0;
			half <= ~half;
			bit_tick <= half;
		end else begin
			count <= count + 1'b1;
			bit_tick <= 1'b0;
		end
	end
endmodule // uartsb_baud_gen
`default_nettype wire

// [rtl/uartsb_ctrl.sv]
// sync break transmit/receive control with self-clearing triggers
`timescale 1ns/1ps
`default_nettype none
module uartsb_ctrl
	import uartsb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic port_power_enable, // mode register bit 7
	input wire logic transmit_enable_bit, // mode register bit 6
	input wire logic receive_enable_bit, // mode register bit 5
	input wire logic [7:0] baud_divisor, // 8-bit counter compare
	input wire logic ctrl_wr, // one-cycle write strobe
	input wire logic [7:0] ctrl_wdata,
	input wire logic rxd, // serial line in, asynchronous
	output logic [7:0] ctrl_rdata,
	output logic txd,
	output logic break_receive_status_flag,
	output logic break_transmit_busy,
	output logic transmit_complete_interrupt,
	output logic receive_complete_interrupt
);
	////////////////////////////////////////////////////////////////////////
	// reset release
	// assert at once, release through two flops so all state leaves reset on one edge
	logic rst_meta_b;
	logic rst_sync_b; // released copy used everywhere below

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// line input synchroniser: three stages, level accepted when 2 and 3 agree
	logic rxd_s1;
	logic rxd_s2;
	logic rxd_s3;
	logic rxd_level; // filtered line level
	// a one-clock line glitch never makes stages two and three agree, so it is dropped

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			rxd_s3 <= 1'b1;
			rxd_level <= 1'b1;
		end else begin
			rxd_s1 <= rxd;
			rxd_s2 <= rxd_s1;
			rxd_s3 <= rxd_s2;
			// only the later two stages are compared, never the first
			if (rxd_s2 == rxd_s3) begin
				rxd_level <= rxd_s3;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// communication-active qualifiers
	logic tx_active;
	logic rx_active;
	logic wr_rx_trig;
	logic wr_tx_trig;

	// one decode for both triggers: a written 1 counts only while its direction runs
	function automatic logic trig_hit(input logic wr, input logic trig_bit, input logic active);
		return wr & trig_bit & active;
	endfunction

	always_comb begin
		tx_active = port_power_enable & transmit_enable_bit;
		rx_active = port_power_enable & receive_enable_bit;
		// a 1 in a trigger bit starts work even if the same value is rewritten
		wr_rx_trig = trig_hit(ctrl_wr, ctrl_wdata[UARTSB_CTL_RX_TRIG_POS], rx_active);
		wr_tx_trig = trig_hit(ctrl_wr, ctrl_wdata[UARTSB_CTL_TX_TRIG_POS], tx_active);
	end

	////////////////////////////////////////////////////////////////////////
	// option bits of the control register; triggers read back as zero
	logic [7:0] ctl_opts;

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctl_opts <= UARTSB_CTL_RESET & UARTSB_CTL_KEEP_MASK;
		end else if (ctrl_wr) begin
			// a same-value rewrite simply stores the same options again
			ctl_opts <= ctrl_wdata & UARTSB_CTL_KEEP_MASK;
		end
	end

	// read port is its own flop, so reads lag a write by two edges
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_rdata <= 8'h00;
		end else begin
			ctrl_rdata <= ctl_opts;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// baud tick, shared by both break sequencers
	logic bit_tick;
	logic baud_run;
	logic rx_trig; // internal receive trigger, never visible on reads
	uartsb_rx_state_t rx_state;

	// the counter idles between sequences, so each sequence started from idle begins on a fresh phase;
	// bit_tick is registered, so each count lands one clock after the counter wrap that makes it
	assign baud_run = break_transmit_busy | rx_trig;

	uartsb_baud_gen #(
		.DIV_W(8)
	) u_baud (
		.clk_sys(clk_sys),
		.rst_sync_b(rst_sync_b),
		.run(baud_run),
		.divisor(baud_divisor),
		.bit_tick(bit_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// break transmit: line held low for a fixed count of bit periods
	logic [4:0] tx_count;

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			break_transmit_busy <= 1'b0;
			tx_count <= 5'h00;
			txd <= 1'b1;
			transmit_complete_interrupt <= 1'b0;
		end else begin
			transmit_complete_interrupt <= 1'b0;
			if (!tx_active) begin
				// power or enable dropped: abort quietly, line to idle
				break_transmit_busy <= 1'b0;
				txd <= 1'b1;
			end else if (wr_tx_trig) begin
				// a rewrite with the bit set restarts the field from zero
				break_transmit_busy <= 1'b1;
				tx_count <= 5'h00;
				txd <= 1'b0;
			end else if (break_transmit_busy && bit_tick) begin
				// the tick that ends the last period also frees the line
				if (tx_count == UARTSB_BRK_TX_BITS - 5'h01) begin
					break_transmit_busy <= 1'b0;
					txd <= 1'b1;
					transmit_complete_interrupt <= 1'b1;
				end else begin
					tx_count <= tx_count + 5'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// break receive sequencer
	logic [4:0] rx_count;

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rx_state <= UARTSB_RX_IDLE;
			rx_count <= 5'h00;
			rx_trig <= 1'b0;
			break_receive_status_flag <= 1'b0;
			receive_complete_interrupt <= 1'b0;
		end else begin
			receive_complete_interrupt <= 1'b0;
			if (!rx_active) begin
				rx_state <= UARTSB_RX_IDLE;
				rx_trig <= 1'b0;
			end else if (wr_rx_trig) begin
				// a rewrite after self-clear starts a fresh reception
				rx_trig <= 1'b1;
				rx_state <= UARTSB_RX_WAIT;
				rx_count <= 5'h00;
				break_receive_status_flag <= 1'b1;
			end else begin
				case (rx_state)
					UARTSB_RX_IDLE: begin
						// nothing to time until a trigger arrives
						rx_count <= 5'h00;
					end
					UARTSB_RX_WAIT: begin
						// wait for the line to fall
						rx_count <= 5'h00;
						if (!rxd_level) begin
							rx_state <= UARTSB_RX_LOW;
						end
					end
					UARTSB_RX_LOW: begin
						if (rxd_level) begin
							if (rx_count >= UARTSB_BRK_RX_MIN_BITS) begin
								// good field: trigger and flag drop as the interrupt fires
								rx_trig <= 1'b0;
								break_receive_status_flag <= 1'b0;
								receive_complete_interrupt <= 1'b1;
								rx_state <= UARTSB_RX_IDLE;
							end else begin
								// too short: back to waiting, flag stays set
								rx_state <= UARTSB_RX_WAIT;
								break_receive_status_flag <= 1'b1;
							end
						end else if (bit_tick && rx_count != UARTSB_BRK_CNT_MAX) begin
							// saturate so a stuck-low line cannot wrap to short
							rx_count <= rx_count + 5'h01;
						end
					end
					default: begin
						// unused code: back to idle and clear rx_trig; the baud counter stops unless a transmit is busy
						rx_state <= UARTSB_RX_IDLE;
						rx_trig <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // uartsb_ctrl
`default_nettype wire

// [dv/uartsb_line_node.sv]
// remote serial node model that pulls the shared line low for a break
`timescale 1ns/1ps
`default_nettype none
module uartsb_line_node (
	input wire logic clk_sys,
	output var logic rxd
);
	// the line idles high between fields, as a pulled-up bus would
	initial rxd = 1'b1;
	// hold the line low for a set number of clocks; short holds make a bad field
	task automatic drive_low(input int clocks);
		@(negedge clk_sys);
		rxd = 1'b0;
		repeat (clocks) @(negedge clk_sys);
		rxd = 1'b1;
	endtask
endmodule // uartsb_line_node
`default_nettype wire

// [dv/uartsb_ctrl_chk.sv]
// concurrent checks on the ports of the sync break control block
`timescale 1ns/1ps
`default_nettype none
module uartsb_ctrl_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic port_power_enable,
	input wire logic transmit_enable_bit,
	input wire logic receive_enable_bit,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic txd,
	input wire logic break_receive_status_flag,
	input wire logic break_transmit_busy,
	input wire logic transmit_complete_interrupt,
	input wire logic receive_complete_interrupt
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	property p_trig_read; ctrl_rdata[7:5] == 3'h0; endproperty
	a_trig_read: assert property (p_trig_read) else $error("trigger bits read nonzero");
	// a same-cycle trigger write wins over completion, so leave it out
	property p_rx_done;
		receive_complete_interrupt && !$past(ctrl_wr) |-> !break_receive_status_flag;
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("flag kept after good break");
	property p_rx_pulse; receive_complete_interrupt |=> !receive_complete_interrupt; endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("receive pulse too long");
	property p_flag_hold; $fell(break_receive_status_flag) |-> receive_complete_interrupt; endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without break");
	property p_rx_start;
		ctrl_wr && ctrl_wdata[6] && port_power_enable && receive_enable_bit
			|=> break_receive_status_flag;
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("receive trigger ignored");
	property p_tx_start;
		ctrl_wr && ctrl_wdata[5] && port_power_enable && transmit_enable_bit
			|=> break_transmit_busy && !txd;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("transmit trigger ignored");
	property p_opts; ctrl_wr |-> ##2 ctrl_rdata[4:0] == $past(ctrl_wdata[4:0], 2); endproperty
	a_opts: assert property (p_opts) else $error("options not stored");
	// an abort drops busy with the direction off and gives no pulse, so it is left out
	property p_tx_done;
		$fell(break_transmit_busy) && $past(port_power_enable && transmit_enable_bit)
			|-> transmit_complete_interrupt;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("no pulse at break end");
	property p_tx_pulse;
		transmit_complete_interrupt
			|-> (!break_transmit_busy && txd) ##1 !transmit_complete_interrupt;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("transmit pulse malformed");
endmodule // uartsb_ctrl_chk
bind uartsb_ctrl uartsb_ctrl_chk u_chk (.clk_sys, .rst_b, .port_power_enable,
	.transmit_enable_bit, .receive_enable_bit, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .txd,
	.break_receive_status_flag, .break_transmit_busy, .transmit_complete_interrupt,
	.receive_complete_interrupt);
`default_nettype wire

// [dv/uart_sync_break_control_test.sv]
// self-checking bench for the sync break control block
`timescale 1ns/1ps
`default_nettype none
module uart_sync_break_control_test;
	logic clk_sys = 1'b0, rst_b = 1'b0, pwr = 1'b1, txe = 1'b1, rxe = 1'b1, ctrl_wr = 1'b0;
	logic [7:0] div = 8'h00, wdata = 8'h00, rdata;
	logic rxd, txd, rx_flag, tx_busy, tx_done, rx_done;
	logic [31:0] seed = 32'h295AD3C4;
	int err_count = 0, n_checks = 0, rx_pulses = 0, tx_pulses = 0, n;
	always #4 clk_sys = ~clk_sys;
	uartsb_ctrl uut (.clk_sys, .rst_b, .port_power_enable(pwr), .transmit_enable_bit(txe),
		.receive_enable_bit(rxe), .baud_divisor(div), .ctrl_wr, .ctrl_wdata(wdata), .rxd,
		.ctrl_rdata(rdata), .txd, .break_receive_status_flag(rx_flag),
		.break_transmit_busy(tx_busy), .transmit_complete_interrupt(tx_done),
		.receive_complete_interrupt(rx_done));
	uartsb_line_node node (.clk_sys, .rxd);
	// count receive and transmit pulses; case equality keeps an unknown from counting
	always @(posedge clk_sys) rx_pulses <= rx_pulses + int'(rx_done === 1'b1);
	always @(posedge clk_sys) tx_pulses <= tx_pulses + int'(tx_done === 1'b1);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// break length in clocks: 13 bit periods, each twice the counter period,
	// plus one clock for the registered bit tick to reach the sequencer
	function automatic int tx_len(logic [7:0] d);
		return 26 * (int'(d) + 1) + 1;
	endfunction
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one-cycle write strobe launched off the falling edge
	task automatic wr(logic [7:0] v);
		@(negedge clk_sys);
		ctrl_wr = 1'b1;
		wdata = v;
		@(negedge clk_sys);
		ctrl_wr = 1'b0;
	endtask
	// bounded wait; running out ends the run as a failure
	// on_flag selects the receive flag, otherwise the serial output is watched
	task automatic wait_for(input bit on_flag, input logic v);
		n = 0;
		while ((on_flag ? rx_flag : txd) !== v && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 400) begin
			err_count++;
			close_out();
		end
	endtask
	initial begin
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (4) @(negedge clk_sys);
		check("reset read", rdata, 8'h01);
		// transmit breaks at random rates, refreshing the register midway
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			div = {6'h00, seed[1:0]};
			wr({3'h1, seed[8:4]});
			check("busy at start", 8'(tx_busy), 8'h01);
			wait_for(1'b0, 1'b0);
			n = 0;
			while (txd === 1'b0 && n < 300) begin
				n++;
				@(negedge clk_sys);
				ctrl_wr = (n == 4);
				wdata = rdata;
			end
			check("break length", 8'(n), 8'(tx_len(div)));
			@(negedge clk_sys);
			check("transmit pulses", 8'(tx_pulses), 8'(i + 1));
			check("busy at end", 8'(tx_busy), 8'h00);
			check("refresh read", rdata, {3'h0, seed[8:4]});
		end
		$display("test transmit done");
		// receive: a short low field first, then a proper break without a new trigger
		div = 8'h00;
		wr(8'h40);
		@(negedge clk_sys);
		check("flag after trigger", 8'(rx_flag), 8'h01);
		node.drive_low(16);
		repeat (8) @(negedge clk_sys);
		check("flag after error", 8'(rx_flag), 8'h01);
		check("pulse after error", 8'(rx_pulses), 8'h00);
		node.drive_low(26);
		wait_for(1'b1, 1'b0);
		// the pulse counter moves one edge after the flag falls
		@(negedge clk_sys);
		check("pulse after break", 8'(rx_pulses), 8'h01);
		check("trigger read", rdata, 8'h00);
		wr(8'h40);
		@(negedge clk_sys);
		check("retrigger flag", 8'(rx_flag), 8'h01);
		node.drive_low(26);
		wait_for(1'b1, 1'b0);
		@(negedge clk_sys);
		check("second pulse", 8'(rx_pulses), 8'h02);
		$display("test receive done");
		// refused: both triggers written while their directions are off
		rxe = 1'b0;
		txe = 1'b0;
		wr(8'h60);
		repeat (2) @(negedge clk_sys);
		check("refused receive", 8'(rx_flag), 8'h00);
		check("refused transmit", 8'(txd), 8'h01);
		check("refused pulses", 8'(tx_pulses), 8'h03);
		$display("test refused done");
		close_out();
	end
endmodule // uart_sync_break_control_test
`default_nettype wire
